// [output_compare_pkg.sv]
// Constants shared by the output compare unit.
// Assumes a 16-bit timer count and 16-bit compare values.
package output_compare_pkg;
  // ==========================================================
  // Widths and field positions
  localparam int COUNT_W = 16;
  localparam int CTRL_W = 16;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  // ==========================================================
  // Mode field codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_ONE_LOW = 3'h1;
  localparam logic [2:0] MODE_ONE_HIGH = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_DELAYED = 3'h4;
  localparam logic [2:0] MODE_PULSE = 3'h5;
  localparam logic [2:0] MODE_PWM = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT = 3'h7;
  // ==========================================================
  // Reset values
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic PIN_RESET = 1'b0;
  localparam logic FAULT_LEVEL_RESET = 1'b1;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
endpackage

// [output_compare_modes.sv]
// Output compare unit: drives one compare pin from a timer count and two compare values.
// Assumes the timer count and control inputs are synchronous to clk_in; the fault input is a pin.
`timescale 1ns/1ps
module output_compare_modes (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Configuration and timer
  input wire logic [15:0] compare_control_reg_in,
  input wire logic [15:0] primary_compare_value_in,
  input wire logic [15:0] secondary_compare_value_in,
  input wire logic [15:0] timer_count_in,
  // Port logic and fault pin
  input wire logic gpio_level_in,
  input wire logic fault_input_a_in,
  // Pin and event
  output logic compare_output_pin_out,
  output logic pin_owned_out,
  output logic compare_irq_out
);

  // ==========================================================
  // Helpers
  function automatic logic hits(input logic [15:0] a, input logic [15:0] b);
    hits = (a == b);
  endfunction

  logic [2:0] mode;
  logic [2:0] mode_q;
  logic entry;
  logic match_p;
  logic match_s;
  logic at_zero;
  logic primary_nz;
  logic pin_q, pin_d;
  logic done_q, done_d;
  logic trip_q;
  logic irq_d;
  logic rise, fall;
  logic fsync1_q, fsync2_q, fsync3_q;
  logic fault_lvl_q;
  logic fault_fall;

  assign mode = compare_control_reg_in[output_compare_pkg::MODE_MSB:output_compare_pkg::MODE_LSB];
  assign entry = (mode != mode_q);
  assign match_p = hits(timer_count_in, primary_compare_value_in);
  assign match_s = hits(timer_count_in, secondary_compare_value_in);
  assign at_zero = hits(timer_count_in, output_compare_pkg::COUNT_ZERO);
  assign primary_nz = !hits(primary_compare_value_in, output_compare_pkg::COUNT_ZERO);

  // ==========================================================
  // Fault pin synchroniser, three stages; level moves when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fsync1_q <= output_compare_pkg::FAULT_LEVEL_RESET;
      fsync2_q <= output_compare_pkg::FAULT_LEVEL_RESET;
      fsync3_q <= output_compare_pkg::FAULT_LEVEL_RESET;
    end else begin
      fsync1_q <= fault_input_a_in;
      fsync2_q <= fsync1_q;
      fsync3_q <= fsync2_q;
    end
  end

  // Filtered fault level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_lvl_q <= output_compare_pkg::FAULT_LEVEL_RESET;
    end else if (fsync2_q == fsync3_q) begin
      fault_lvl_q <= fsync3_q;
    end
  end

  assign fault_fall = fault_lvl_q && (fsync2_q == fsync3_q) && !fsync3_q;

  // ==========================================================
  // Next pin level per mode
  always_comb begin
    pin_d = pin_q;
    done_d = done_q;
    if (entry) begin
      done_d = 1'b0;
      unique case (mode)
        output_compare_pkg::MODE_OFF: pin_d = gpio_level_in;
        output_compare_pkg::MODE_ONE_LOW: pin_d = 1'b0;
        output_compare_pkg::MODE_ONE_HIGH: pin_d = 1'b1;
        output_compare_pkg::MODE_TOGGLE: pin_d = pin_q;
        output_compare_pkg::MODE_DELAYED,
        output_compare_pkg::MODE_PULSE: pin_d = 1'b0;
        output_compare_pkg::MODE_PWM,
        output_compare_pkg::MODE_PWM_FAULT: pin_d = primary_nz;
      endcase
    end else begin
      unique case (mode)
        output_compare_pkg::MODE_OFF: pin_d = gpio_level_in;
        output_compare_pkg::MODE_ONE_LOW: begin
          if (match_p && !done_q) begin
            pin_d = 1'b1;
            done_d = 1'b1;
          end
        end
        output_compare_pkg::MODE_ONE_HIGH: begin
          if (match_p && !done_q) begin
            pin_d = 1'b0;
            done_d = 1'b1;
          end
        end
        output_compare_pkg::MODE_TOGGLE: begin
          if (match_p) begin
            pin_d = !pin_q;
          end
        end
        output_compare_pkg::MODE_DELAYED: begin
          if (!done_q && match_s && pin_q) begin
            pin_d = 1'b0;
            done_d = 1'b1;
          end else if (!done_q && match_p) begin
            pin_d = 1'b1;
          end
        end
        output_compare_pkg::MODE_PULSE: begin
          if (match_s && pin_q) begin
            pin_d = 1'b0;
          end else if (match_p) begin
            pin_d = 1'b1;
          end
        end
        // PWM high from count zero until duty match; a tripped fault holds it low
        output_compare_pkg::MODE_PWM,
        output_compare_pkg::MODE_PWM_FAULT: begin
          if (trip_q || (fault_fall && mode == output_compare_pkg::MODE_PWM_FAULT)) begin
            pin_d = 1'b0;
          end else if (match_p) begin
            pin_d = 1'b0;
          end else if (at_zero && primary_nz) begin
            pin_d = 1'b1;
          end
        end
      endcase
    end
  end

  assign rise = pin_d && !pin_q;
  assign fall = !pin_d && pin_q;

  // Interrupt choice per mode; entry edges are setup, not events
  always_comb begin
    irq_d = 1'b0;
    if (!entry) begin
      unique case (mode)
        output_compare_pkg::MODE_OFF: irq_d = 1'b0;
        output_compare_pkg::MODE_ONE_LOW: irq_d = rise;
        output_compare_pkg::MODE_ONE_HIGH: irq_d = fall;
        output_compare_pkg::MODE_TOGGLE: irq_d = rise || fall;
        output_compare_pkg::MODE_DELAYED,
        output_compare_pkg::MODE_PULSE: irq_d = fall;
        output_compare_pkg::MODE_PWM: irq_d = 1'b0;
        output_compare_pkg::MODE_PWM_FAULT: irq_d = fault_fall;
      endcase
    end
  end

  // ==========================================================
  // Pin, ownership, event and mode registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_q <= output_compare_pkg::PIN_RESET;
      done_q <= 1'b0;
      mode_q <= output_compare_pkg::MODE_RESET;
      pin_owned_out <= 1'b0;
      compare_irq_out <= 1'b0;
    end else begin
      pin_q <= pin_d;
      done_q <= done_d;
      mode_q <= mode;
      pin_owned_out <= (mode != output_compare_pkg::MODE_OFF);
      compare_irq_out <= irq_d;
    end
  end

  assign compare_output_pin_out = pin_q;

  // Fault trip latch; a fault in the same cycle as re-entry still trips
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trip_q <= 1'b0;
    end else if (fault_fall && mode == output_compare_pkg::MODE_PWM_FAULT) begin
      trip_q <= 1'b1;
    end else if (entry) begin
      trip_q <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  logic steady;
  assign steady = !entry;

  property p_mode_own;
    @(posedge clk_in) disable iff (rst_in)
    1'b1 |=> (pin_owned_out == ($past(mode) != output_compare_pkg::MODE_OFF));
  endproperty
  a_mode_own: assert property (p_mode_own) else $error("ownership does not follow mode");

  property p_off_gpio;
    @(posedge clk_in) disable iff (rst_in)
    (mode == output_compare_pkg::MODE_OFF) |=> (!pin_owned_out && compare_output_pin_out == $past(gpio_level_in));
  endproperty
  a_off_gpio: assert property (p_off_gpio) else $error("disabled pin not following port");

  property p_toggle;
    @(posedge clk_in) disable iff (rst_in)
    (steady && mode == output_compare_pkg::MODE_TOGGLE && match_p) |=>
      (compare_output_pin_out != $past(compare_output_pin_out)) && compare_irq_out;
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle match missed");

  property p_toggle_entry;
    @(posedge clk_in) disable iff (rst_in)
    (entry && mode == output_compare_pkg::MODE_TOGGLE) |=> $stable(compare_output_pin_out) && !compare_irq_out;
  endproperty
  a_toggle_entry: assert property (p_toggle_entry) else $error("toggle entry moved pin");

  property p_pwm_init;
    @(posedge clk_in) disable iff (rst_in)
    (entry && mode[2:1] == 2'h3) |=> (compare_output_pin_out == $past(primary_nz));
  endproperty
  a_pwm_init: assert property (p_pwm_init) else $error("pwm initial level wrong");

  property p_pwm_quiet;
    @(posedge clk_in) disable iff (rst_in)
    (mode == output_compare_pkg::MODE_PWM) |=> !compare_irq_out;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm raised interrupt");

  property p_fault;
    @(posedge clk_in) disable iff (rst_in)
    (steady && mode == output_compare_pkg::MODE_PWM_FAULT && fault_fall) |=>
      compare_irq_out && !compare_output_pin_out ##1 !compare_output_pin_out;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not handled");

  property p_oneshot_low;
    @(posedge clk_in) disable iff (rst_in)
    (entry && mode == output_compare_pkg::MODE_ONE_LOW) |=> !compare_output_pin_out;
  endproperty
  a_oneshot_low: assert property (p_oneshot_low) else $error("one-shot low start wrong");

  property p_oneshot_fire;
    @(posedge clk_in) disable iff (rst_in)
    (steady && mode == output_compare_pkg::MODE_ONE_LOW && match_p && !done_q) |=>
      compare_output_pin_out && compare_irq_out;
  endproperty
  a_oneshot_fire: assert property (p_oneshot_fire) else $error("one-shot did not fire");

  property p_pulse_fall;
    @(posedge clk_in) disable iff (rst_in)
    (steady && mode == output_compare_pkg::MODE_PULSE && match_s && pin_q) |=>
      !compare_output_pin_out && compare_irq_out;
  endproperty
  a_pulse_fall: assert property (p_pulse_fall) else $error("pulse fall missed");

  c_toggle: cover property (@(posedge clk_in) disable iff (rst_in)
    steady && mode == output_compare_pkg::MODE_TOGGLE && match_p);
  c_pulse: cover property (@(posedge clk_in) disable iff (rst_in)
    steady && mode == output_compare_pkg::MODE_PULSE && fall);
  c_fault: cover property (@(posedge clk_in) disable iff (rst_in)
    mode == output_compare_pkg::MODE_PWM_FAULT && fault_fall);

endmodule // output_compare_modes

// [compare_load_model.sv]
// Far side of the compare pin: the load it drives and the fault source.
// Assumes the bench pulses trip_in for one cycle to ask for a fault.
`timescale 1ns/1ps
module compare_load_model (
  // Clock
  input wire logic clk_in,
  // Pin seen and fault request
  input wire logic pin_in,
  input wire logic trip_in,
  // Fault line and edge count
  output logic fault_n_out,
  output int edges_out
);
  // ==========================================
  // Fault source
  int low_q;
  // falling fault edge
  // Pulled-up line, so it idles high; held low 4 cycles per trip
  always_ff @(posedge clk_in) begin
    low_q <= #2 trip_in ? 4 : (low_q > 0 ? low_q - 1 : 0);
  end
  assign fault_n_out = (low_q == 0);
  // Counts rising pin edges as they land, so the count is current just after any clock edge
  always @(posedge pin_in) begin
    edges_out <= edges_out + 1;
  end
endmodule // compare_load_model

// [output_compare_modes_tb_top.sv]
// Self-checking bench: reference model of every mode, compared each cycle.
// Assumes a small wrapping timer so compare matches come often.
`timescale 1ns/1ps
module output_compare_modes_tb_top;
  logic clk_in, rst_in, gpio, trip, fault_n, pin, owned, irq;
  logic [15:0] ctrl, prim, sec, tmr;
  logic [7:0] rnd;
  int mismatches, checks, edges, w, m_mode, m_pin, m_irq, m_done, m_trip, m_rises;
  bit cmp_en, run_tmr;
  // ==========================================
  // Design and far side
  output_compare_modes uut (.clk_in(clk_in), .rst_in(rst_in), .compare_control_reg_in(ctrl),
    .primary_compare_value_in(prim), .secondary_compare_value_in(sec), .timer_count_in(tmr),
    .gpio_level_in(gpio), .fault_input_a_in(fault_n), .compare_output_pin_out(pin),
    .pin_owned_out(owned), .compare_irq_out(irq));
  compare_load_model load (.clk_in(clk_in), .pin_in(pin), .trip_in(trip), .fault_n_out(fault_n),
    .edges_out(edges));
  initial begin
    clk_in = 0;
    forever #12.5 clk_in = ~clk_in;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Timer wraps at 15 to keep matches frequent
  always @(posedge clk_in) if (run_tmr) tmr <= #2 (tmr == 16'h000f) ? 16'h0000 : tmr + 16'h0001;
  // ==========================================
  // Reference model, updated at each rising edge
  always @(posedge clk_in) begin : ref_model
    int m;
    bit hit, hit2;
    int prev;
    prev = m_pin;
    m = ctrl[2:0];
    hit = (tmr == prim);
    hit2 = (tmr == sec);
    m_irq = 0;
    if (rst_in) m_pin = 0;
    else if (m == 0) m_pin = gpio;
    else if (m != m_mode) begin
      m_done = 0;
      m_trip = 0;
      case (m)
        1, 4, 5: m_pin = 0;
        2: m_pin = 1;
        6, 7: m_pin = (prim != 0);
        default: ;
      endcase
    end else case (m)
      1, 2: if (!m_done && hit) begin
        m_pin = (m == 1);
        m_irq = 1;
        m_done = 1;
      end
      3: if (hit) begin
        m_pin = !m_pin;
        m_irq = 1;
      end
      4, 5: if (m_pin && hit2 && !m_done) begin
        m_pin = 0;
        m_irq = 1;
        m_done = (m == 4);
      end else if (!m_pin && hit && !m_done) m_pin = 1;
      default: if (!m_trip) begin
        if (hit) m_pin = 0;
        else if (tmr == 0) m_pin = 1;
      end
    endcase
    m_mode = rst_in ? 0 : m;
    // Expected rising edges at the far side
    if (m_pin == 1 && prev == 0) m_rises++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Outputs are settled by the falling edge
  always @(negedge clk_in) if (cmp_en) begin
    check(pin, 16'(m_pin));
    check(owned, 16'(m_mode != 0));
    check(irq, 16'(m_irq));
  end
  task automatic complete_run;
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic set_mode(input logic [2:0] m, input int n);
    run_tmr = 0;
    @(posedge clk_in);
    #2 rnd = lfsr(rnd);
    prim = {12'h000, rnd[3:0]};
    sec = {12'h000, rnd[7:4]};
    // Upper control bits are noise the unit must ignore
    ctrl = {5'h00, rnd, m};
    @(posedge clk_in);
    #2 run_tmr = 1;
    repeat (n) begin
      @(posedge clk_in);
      #2 rnd = lfsr(rnd);
      gpio = rnd[0];
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst_in = 1;
    ctrl = 16'h0000;
    prim = 16'h0005;
    sec = 16'h000a;
    tmr = 16'h0000;
    gpio = 0;
    trip = 0;
    rnd = 8'h61;
    cmp_en = 0;
    run_tmr = 0;
    mismatches = 0;
    checks = 0;
    @(posedge clk_in);
    cmp_en = 1;
    repeat (7) @(posedge clk_in);
    #2 rst_in = 0;
    // Every code in turn, then a random order of entries
    for (int r = 0; r < 2; r++) for (int m = 0; m < 8; m++) set_mode(m[2:0], 50);
    for (int k = 0; k < 24; k++) set_mode(rnd[2:0], 40);
    set_mode(3'h6, 20);
    set_mode(3'h3, 40);
    // Fault trip in protected PWM, timer stopped
    set_mode(3'h7, 6);
    run_tmr = 0;
    @(posedge clk_in);
    #2 cmp_en = 0;
    trip = 1;
    @(posedge clk_in);
    #2 trip = 0;
    w = 0;
    while (irq !== 1'b1 && w < 12) begin
      @(negedge clk_in);
      w++;
    end
    check(16'(w < 12), 16'h0001);
    @(posedge clk_in);
    #2 check(pin, 16'h0000);
    m_trip = 1;
    m_pin = 0;
    run_tmr = 1;
    @(negedge clk_in);
    cmp_en = 1;
    repeat (40) @(posedge clk_in);
    // Rearm by leaving and re-entering the mode
    set_mode(3'h6, 20);
    set_mode(3'h7, 40);
    // Reset in mid-run; mode 111 is entered afresh once it is released
    rst_in = 1;
    repeat (3) @(posedge clk_in);
    #2 rst_in = 0;
    repeat (20) @(posedge clk_in);
    #2 check(16'(edges != 0), 16'h0001);
    check(16'(edges), 16'(m_rises));
    complete_run();
  end
endmodule // output_compare_modes_tb_top
